// File: logic/sqf_status.sv
// sqf_status: fault and limit flags of the sample queue, with apb access.
// assumes queue signals come from logic on pclk, so none is synchronised.
// Function
// (RULE1) refused read during write sets bit 5
// (RULE2) granted read or empty queue clears it
// (RULE3) read fault interrupt follows its flag
// (RULE4) enabled channel result >= upper sets bit 4
// (RULE5) empty clears upper flag; interrupt follows
// (RULE6) lower limit hit flag sits at bit 3
// (RULE7) flags reset zero, software writes ignored
// (RULE8) lower flag enabled only; emptied clears it
// (RULE9) count back to zero means emptied
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module sqf_status #(
    parameter int RESULT_W = sqf_pkg::RESULT_W_DEF,
    parameter int CHANNELS = sqf_pkg::CHANNELS_DEF,
    parameter int COUNT_W  = sqf_pkg::COUNT_W_DEF,
    parameter int CH_W     = $clog2(CHANNELS)
) (
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // queue read side
    input  wire logic                read_request,
    output logic                     read_grant,
    // queue write side
    input  wire logic                write_busy,
    input  wire logic                store_valid,
    input  wire logic [CH_W-1:0]     store_channel,
    input  wire logic [RESULT_W-1:0] store_result,
    // queue occupancy and neighbouring fault bits
    input  wire logic [COUNT_W-1:0]  queue_count,
    input  wire logic                write_fault,
    input  wire logic                overrun,
    // interrupts
    output logic                     irq_read_fault,
    output logic                     irq_upper_limit,
    output logic                     irq_lower_limit,
    output logic                     irq
);

    // flag state
    logic                read_fault_r;      // read fault flag
    logic                read_fault_nxt;
    logic                upper_limit_hit_r; // upper limit hit flag
    logic                upper_limit_hit_nxt;
    logic                lower_limit_hit_r; // lower limit hit flag
    logic                lower_limit_hit_nxt;
    logic                count_busy_r;      // queue held data last cycle
    logic                count_busy_nxt;

    // software settings
    logic [RESULT_W-1:0] upper_limit_value_r;
    logic [RESULT_W-1:0] upper_limit_value_nxt;
    logic [RESULT_W-1:0] lower_limit_value_r;
    logic [RESULT_W-1:0] lower_limit_value_nxt;
    logic [CHANNELS-1:0] limit_enable_r;    // channel limit check enables
    logic [CHANNELS-1:0] limit_enable_nxt;
    logic [2:0]          evt_status_r;      // sticky events
    logic [2:0]          evt_status_nxt;
    logic [2:0]          evt_enable_r;      // event mask
    logic [2:0]          evt_enable_nxt;

    // bus answer state
    logic [31:0]         prdata_r;
    logic [31:0]         prdata_nxt;
    logic                pslverr_r;
    logic                pslverr_nxt;

    // decoded strobes and helpers
    logic                setup_phase;       // first cycle of a transfer
    logic                wr_commit;         // write takes effect this edge
    logic                addr_known;        // address hits a register
    logic                queue_emptied;     // occupancy fell to zero
    logic                read_refused;      // read collided with a write
    logic                upper_hit_event;
    logic                lower_hit_event;
    logic [7:0]          status_view;       // queue status as read
    logic [2:0]          evt_set;           // rising edges of the flags
    logic [2:0]          evt_clr;           // software clear bits

    // per result limit checks
    sqf_limit_cmp #(
        .RESULT_W (RESULT_W),
        .CHANNELS (CHANNELS),
        .CH_W     (CH_W)
    ) sqf_limit_cmp_i (
        .store_valid                (store_valid),
        .store_channel              (store_channel),
        .store_result               (store_result),
        .upper_limit_value          (upper_limit_value_r),
        .lower_limit_value          (lower_limit_value_r),
        .channel_limit_check_enable (limit_enable_r),
        .upper_hit_event            (upper_hit_event),
        .lower_hit_event            (lower_hit_event)
    );

    // queue handshake and emptied detection
    always_comb begin
        // a read is refused while a conversion is being written
        read_refused  = read_request & write_busy;          // [RULE1]
        read_grant    = read_request & ~write_busy;
        // emptied: held data last cycle, count is zero now
        queue_emptied = count_busy_r
                        & (queue_count == '0);              // [RULE9]
        count_busy_nxt = (queue_count != '0);
    end

    // next flag values; a set in the clearing cycle wins
    always_comb begin
        // read fault
        if (read_refused) begin
            read_fault_nxt = 1'b1;                          // [RULE1]
        end else if (read_grant || queue_emptied) begin
            read_fault_nxt = 1'b0;                          // [RULE2]
        end else begin
            read_fault_nxt = read_fault_r;
        end
        // upper limit hit
        if (upper_hit_event) begin
            upper_limit_hit_nxt = 1'b1;                     // [RULE4]
        end else if (queue_emptied) begin
            upper_limit_hit_nxt = 1'b0;                     // [RULE5] [RULE9]
        end else begin
            upper_limit_hit_nxt = upper_limit_hit_r;
        end
        // lower limit hit, armed only for enabled channels
        if (lower_hit_event) begin
            lower_limit_hit_nxt = 1'b1;                     // [RULE6] [RULE8]
        end else if (queue_emptied) begin
            lower_limit_hit_nxt = 1'b0;                     // [RULE8] [RULE9]
        end else begin
            lower_limit_hit_nxt = lower_limit_hit_r;
        end
    end

    // flag registers; status is never loaded from the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_fault_r      <= sqf_pkg::FLAG_RST;         // [RULE7]
            upper_limit_hit_r <= sqf_pkg::FLAG_RST;         // [RULE7]
            lower_limit_hit_r <= sqf_pkg::FLAG_RST;         // [RULE7]
            count_busy_r      <= 1'b0;
        end else begin
            read_fault_r      <= read_fault_nxt;
            upper_limit_hit_r <= upper_limit_hit_nxt;
            lower_limit_hit_r <= lower_limit_hit_nxt;
            count_busy_r      <= count_busy_nxt;
        end
    end

    // flag interrupts are the flags themselves, so they move together
    always_comb begin
        irq_read_fault  = read_fault_r;                     // [RULE3]
        irq_upper_limit = upper_limit_hit_r;                // [RULE5]
        irq_lower_limit = lower_limit_hit_r;                // [RULE8]
    end

    // queue status word as software sees it
    always_comb begin
        status_view = '0;
        status_view[sqf_pkg::BIT_WRITE_FAULT] = write_fault;
        status_view[sqf_pkg::BIT_READ_FAULT]  = read_fault_r;      // [RULE1]
        status_view[sqf_pkg::BIT_UPPER_HIT]   = upper_limit_hit_r; // [RULE4]
        status_view[sqf_pkg::BIT_LOWER_HIT]   = lower_limit_hit_r; // [RULE6]
        status_view[sqf_pkg::BIT_OVERRUN]     = overrun;
    end

    // apb decode; zero wait states, answer prepared in the setup cycle
    always_comb begin
        setup_phase = psel & ~penable;
        wr_commit   = psel & penable & pwrite;
        case (paddr)
            sqf_pkg::OFS_QUEUE_STATUS,
            sqf_pkg::OFS_UPPER_LIMIT,
            sqf_pkg::OFS_LOWER_LIMIT,
            sqf_pkg::OFS_LIMIT_ENABLE,
            sqf_pkg::OFS_EVENT_STATUS,
            sqf_pkg::OFS_EVENT_ENABLE,
            sqf_pkg::OFS_EVENT_CLEAR:  addr_known = 1'b1;
            default:                   addr_known = 1'b0;
        endcase
    end

    // read data and error for the coming access phase
    always_comb begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup_phase) begin
            prdata_nxt  = '0;
            pslverr_nxt = ~addr_known;
            if (!pwrite) begin
                case (paddr)
                    sqf_pkg::OFS_QUEUE_STATUS: begin
                        prdata_nxt[7:0] = status_view;
                    end
                    sqf_pkg::OFS_UPPER_LIMIT: begin
                        prdata_nxt[RESULT_W-1:0] = upper_limit_value_r;
                    end
                    sqf_pkg::OFS_LOWER_LIMIT: begin
                        prdata_nxt[RESULT_W-1:0] = lower_limit_value_r;
                    end
                    sqf_pkg::OFS_LIMIT_ENABLE: begin
                        prdata_nxt[CHANNELS-1:0] = limit_enable_r;
                    end
                    sqf_pkg::OFS_EVENT_STATUS: begin
                        prdata_nxt[2:0] = evt_status_r;
                    end
                    sqf_pkg::OFS_EVENT_ENABLE: begin
                        prdata_nxt[2:0] = evt_enable_r;
                    end
                    // clear register is write only and reads zero
                    default: begin
                        prdata_nxt = '0;
                    end
                endcase
            end
        end
    end

    // software settings; writes to read-only words are dropped silently
    always_comb begin
        upper_limit_value_nxt = upper_limit_value_r;
        lower_limit_value_nxt = lower_limit_value_r;
        limit_enable_nxt      = limit_enable_r;
        evt_enable_nxt        = evt_enable_r;
        evt_clr               = '0;
        if (wr_commit) begin
            case (paddr)
                sqf_pkg::OFS_UPPER_LIMIT: begin
                    upper_limit_value_nxt = pwdata[RESULT_W-1:0];
                end
                sqf_pkg::OFS_LOWER_LIMIT: begin
                    lower_limit_value_nxt = pwdata[RESULT_W-1:0];
                end
                sqf_pkg::OFS_LIMIT_ENABLE: begin
                    limit_enable_nxt = pwdata[CHANNELS-1:0];
                end
                sqf_pkg::OFS_EVENT_ENABLE: begin
                    evt_enable_nxt = pwdata[2:0];
                end
                sqf_pkg::OFS_EVENT_CLEAR: begin
                    evt_clr = pwdata[2:0];
                end
                // queue status and event status ignore writes
                default: begin
                    evt_clr = '0;                           // [RULE7]
                end
            endcase
        end
    end

    // sticky events: a flag rising; set beats a same-cycle clear
    always_comb begin
        evt_set = '0;
        evt_set[sqf_pkg::EVT_READ_FAULT] = read_fault_nxt & ~read_fault_r;
        evt_set[sqf_pkg::EVT_UPPER_HIT]  = upper_limit_hit_nxt
                                           & ~upper_limit_hit_r;
        evt_set[sqf_pkg::EVT_LOWER_HIT]  = lower_limit_hit_nxt
                                           & ~lower_limit_hit_r;
        evt_status_nxt = (evt_status_r & ~evt_clr) | evt_set;
    end

    // settings and bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_limit_value_r <= '1;  // top code: only a top-code result hits until set
            lower_limit_value_r <= '0;
            limit_enable_r      <= '0;  // all channels unchecked
            evt_status_r        <= sqf_pkg::EVT_RST;
            evt_enable_r        <= sqf_pkg::EVT_RST;
            prdata_r            <= '0;
            pslverr_r           <= 1'b0;
        end else begin
            upper_limit_value_r <= upper_limit_value_nxt;
            lower_limit_value_r <= lower_limit_value_nxt;
            limit_enable_r      <= limit_enable_nxt;
            evt_status_r        <= evt_status_nxt;
            evt_enable_r        <= evt_enable_nxt;
            prdata_r            <= prdata_nxt;
            pslverr_r           <= pslverr_nxt;
        end
    end

    // bus outputs and summary interrupt
    always_comb begin
        prdata  = prdata_r;
        // error only counts while pready is high, so it may sit early
        pslverr = pslverr_r;
        pready  = 1'b1;
        irq     = |(evt_status_r & evt_enable_r);
    end

endmodule : sqf_status

// File: pkg/sqf_pkg.sv
// sqf_pkg: constants shared by the sample queue status flag block.
// assumes a 32-bit apb register bus with one aligned word per register.
package sqf_pkg;

    // apb geometry
    localparam int APB_AW        = 8;   // byte address width decoded
    localparam int APB_DW        = 32;  // bus data width

    // register byte offsets
    localparam logic [7:0] OFS_QUEUE_STATUS = 8'h00; // read only flags
    localparam logic [7:0] OFS_UPPER_LIMIT  = 8'h04; // upper limit value
    localparam logic [7:0] OFS_LOWER_LIMIT  = 8'h08; // lower limit value
    localparam logic [7:0] OFS_LIMIT_ENABLE = 8'h0c; // per channel enables
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h10; // sticky events, ro
    localparam logic [7:0] OFS_EVENT_ENABLE = 8'h14; // event irq mask
    localparam logic [7:0] OFS_EVENT_CLEAR  = 8'h18; // write one to clear

    // queue status field positions
    localparam int STATUS_W          = 8;
    localparam int BIT_WRITE_FAULT   = 6;
    localparam int BIT_READ_FAULT    = 5;
    localparam int BIT_UPPER_HIT     = 4;
    localparam int BIT_LOWER_HIT     = 3;
    localparam int BIT_OVERRUN       = 2;

    // event register layout
    localparam int EVT_W             = 3;
    localparam int EVT_READ_FAULT    = 0;
    localparam int EVT_UPPER_HIT     = 1;
    localparam int EVT_LOWER_HIT     = 2;

    // reset values
    localparam logic        FLAG_RST   = 1'b0;
    localparam logic [2:0]  EVT_RST    = 3'h0;

    // documented defaults for the datapath
    localparam int RESULT_W_DEF      = 24;
    localparam int CHANNELS_DEF      = 16;
    localparam int COUNT_W_DEF       = 9;   // holds 0..256 entries

endpackage : sqf_pkg

// File: logic/sqf_limit_cmp.sv
// sqf_limit_cmp: judges one stored result against both limits.
// assumes result, limits and enables are stable in the write cycle.
`timescale 1ns/1ps
module sqf_limit_cmp #(
    parameter int RESULT_W = sqf_pkg::RESULT_W_DEF,
    parameter int CHANNELS = sqf_pkg::CHANNELS_DEF,
    parameter int CH_W     = $clog2(CHANNELS)
) (
    // stored result
    input  wire logic                store_valid,
    input  wire logic [CH_W-1:0]     store_channel,
    input  wire logic [RESULT_W-1:0] store_result,
    // programmed limits
    input  wire logic [RESULT_W-1:0] upper_limit_value,
    input  wire logic [RESULT_W-1:0] lower_limit_value,
    input  wire logic [CHANNELS-1:0] channel_limit_check_enable,
    // verdicts, one cycle with store_valid
    output logic                     upper_hit_event,
    output logic                     lower_hit_event
);

    logic chan_armed;  // channel takes part in limit checks

    // comparisons are unsigned; results arrive as straight binary codes
    always_comb begin
        chan_armed      = store_valid
                          & channel_limit_check_enable[store_channel];
        // equal to the limit counts as a hit on both sides
        upper_hit_event = chan_armed
                          & (store_result >= upper_limit_value); // [RULE4]
        lower_hit_event = chan_armed
                          & (store_result <= lower_limit_value); // [RULE8]
    end

endmodule : sqf_limit_cmp

// File: sim/sqf_status_assertions.sv
// sqf_status_assertions: concurrent checks on the flag block's ports.
// assumes one pclk domain and an async active low presetn.
`timescale 1ns/1ps
module sqf_status_checker #(
    parameter int COUNT_W = 9
) (
    // clock and reset
    input wire logic               pclk,
    input wire logic               presetn,
    // queue side
    input wire logic               read_request,
    input wire logic               write_busy,
    input wire logic               read_grant,
    input wire logic               store_valid,
    input wire logic [COUNT_W-1:0] queue_count,
    // flag interrupts
    input wire logic               irq_read_fault,
    input wire logic               irq_upper_limit,
    input wire logic               irq_lower_limit
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [COUNT_W-1:0] prev_r;  // count at the last edge
    logic               emptied; // count just fell back to zero
    // previous count, so emptied needs a nonzero history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prev_r <= '0;
        else          prev_r <= queue_count;
    end
    assign emptied = (queue_count == '0) && (prev_r != '0);
    sequence s_refused;
        read_request && write_busy;
    endsequence
    sequence s_granted;
        read_grant ##1 !irq_read_fault;
    endsequence
    a_fault_set: assert property (s_refused |=> irq_read_fault)
        else $error("read fault not raised");
    a_fault_clear: assert property (read_grant |-> s_granted)
        else $error("read fault kept after grant");
    a_grant_rule: assert property (
        read_grant == (read_request && !write_busy))
        else $error("grant mismatch");
    a_fault_empty: assert property (
        emptied && !read_request |=> !irq_read_fault)
        else $error("read fault kept after empty");
    a_fault_holds: assert property (!read_request && !emptied |=>
        $stable(irq_read_fault)) else $error("read fault moved alone");
    a_upper_empty: assert property (emptied && !store_valid |=>
        !irq_upper_limit) else $error("upper flag kept after empty");
    a_lower_empty: assert property (emptied && !store_valid |=>
        !irq_lower_limit) else $error("lower flag kept after empty");
    a_limit_holds: assert property (!store_valid && !emptied |=>
        $stable(irq_upper_limit) && $stable(irq_lower_limit))
        else $error("limit flag moved alone");
    a_reset_zero: assert property (disable iff (1'b0) !presetn |->
        !irq_read_fault && !irq_upper_limit && !irq_lower_limit)
        else $error("flag set in reset");
endmodule : sqf_status_checker

// File: sim/sqf_queue_model.sv
// sqf_queue_model: occupancy of the sample queue beside the flag block.
// assumes stores and granted reads are single pclk cycles.
`timescale 1ns/1ps
module sqf_queue_model #(
    parameter int COUNT_W = 4
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // traffic
    input  wire logic               store_valid,
    input  wire logic               read_grant,
    input  wire logic               drain,  // mode logic flushes queue
    output logic        [COUNT_W-1:0] queue_count
);
    // count up on a store, down on a granted read, never below zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)   queue_count <= '0;
        else if (drain) queue_count <= '0;
        else            queue_count <= queue_count + COUNT_W'(store_valid)
                            - COUNT_W'(read_grant && queue_count != '0);
    end
endmodule : sqf_queue_model

// File: sim/sqf_status_tb_top.sv
// sqf_status_tb_top: self-checking bench of the flag block over apb.
// assumes zero wait state apb and the queue model for occupancy.
`timescale 1ns/1ps
module sqf_status_tb_top;
    // presetn falls at time zero so the async resets really fire
    logic        pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
    logic        write_fault = 0, overrun = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, err, read_grant, drain = 0;
    logic        read_request = 0, write_busy = 0, store_valid = 0;
    logic [1:0]  store_channel = '0;
    logic [7:0]  store_result = '0;
    logic [3:0]  queue_count;
    logic        irq_read_fault, irq_upper_limit, irq_lower_limit, irq;
    int          n_fail = 0, n_compared = 0, cycles = 0;
    always #12.5 pclk = ~pclk;
    sqf_status #(.RESULT_W(8), .CHANNELS(4), .COUNT_W(4)) sqf_status_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .read_request(read_request),
        .read_grant(read_grant), .write_busy(write_busy),
        .store_valid(store_valid), .store_channel(store_channel),
        .store_result(store_result), .queue_count(queue_count),
        .write_fault(write_fault), .overrun(overrun),
        .irq_read_fault(irq_read_fault),
        .irq_upper_limit(irq_upper_limit), .irq_lower_limit(irq_lower_limit),
        .irq(irq));
    sqf_queue_model #(.COUNT_W(4)) sqf_queue_model_i (.pclk(pclk),
        .presetn(presetn), .store_valid(store_valid),
        .read_grant(read_grant), .drain(drain), .queue_count(queue_count));
    task results;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; the request stands until pready is seen high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, '0);
        chk(rd, exp);
    endtask : rd_chk
    // one queue cycle of host and converter activity
    task qcyc(input logic rq, input logic bz, input logic sv,
              input logic [1:0] ch, input logic [7:0] v, input logic dr);
        @(posedge pclk);
        read_request <= rq; write_busy <= bz; store_valid <= sv;
        store_channel <= ch; store_result <= v; drain <= dr;
        @(posedge pclk);
        read_request <= 0; write_busy <= 0; store_valid <= 0; drain <= 0;
        // flags load at that edge; look at them once they have settled
        @(negedge pclk);
    endtask : qcyc
    task t_reset;
        rd_chk(8'h00, 32'h0);
        apb(1, 8'h00, 32'hff);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'hff);
        // neighbouring fault levels pass straight into bits 6 and 2
        write_fault <= 1;
        overrun <= 1;
        rd_chk(8'h00, 32'h44);
        write_fault <= 0;
        overrun <= 0;
        apb(0, 8'h40, '0);
        chk({31'h0, err}, 32'h1);
    endtask : t_reset
    task t_fault;
        apb(1, 8'h14, 32'h1);
        qcyc(1, 1, 0, 0, 0, 0);
        chk({31'h0, irq_read_fault}, 32'h1);
        rd_chk(8'h00, 32'h20);
        chk({31'h0, irq}, 32'h1);
        apb(1, 8'h18, 32'h1);
        rd_chk(8'h10, 32'h0);
        chk({31'h0, irq}, 32'h0);
        qcyc(1, 0, 0, 0, 0, 0);
        rd_chk(8'h00, 32'h0);
        qcyc(0, 0, 1, 0, 8'hff, 0);
        qcyc(1, 1, 0, 0, 0, 0);
        chk({31'h0, irq_read_fault}, 32'h1);
        qcyc(0, 0, 0, 0, 0, 1);
        rd_chk(8'h00, 32'h0);
        apb(1, 8'h14, 32'h0);
    endtask : t_fault
    task t_limits;
        static logic [1:0]  ch [6] = '{0, 1, 1, 0, 1, 1};
        static logic [7:0]  v [6] = '{8'hff, 8'h7f, 8'h11, 8'h00,
                                      8'h80, 8'h10};
        static logic [31:0] e [6] = '{0, 0, 0, 0, 32'h10, 32'h18};
        apb(1, 8'h04, 32'h80);
        apb(1, 8'h08, 32'h10);
        apb(1, 8'h0c, 32'h2);
        for (int i = 0; i < 6; i++) begin
            qcyc(0, 0, 1, ch[i], v[i], 0);
            rd_chk(8'h00, e[i]);
        end
        chk({30'h0, irq_upper_limit, irq_lower_limit}, 32'h3);
        // six stores went in, so six granted reads empty the queue
        for (int i = 0; i < 6; i++) qcyc(1, 0, 0, 0, 0, 0);
        rd_chk(8'h00, 32'h0);
    endtask : t_limits
    // cut a hang short
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_fault();
        t_limits();
        results();
    end
endmodule : sqf_status_tb_top
bind sqf_status sqf_status_checker #(.COUNT_W(COUNT_W)) chk_i (
    .pclk(pclk), .presetn(presetn), .read_request(read_request),
    .write_busy(write_busy), .read_grant(read_grant),
    .store_valid(store_valid), .queue_count(queue_count),
    .irq_read_fault(irq_read_fault), .irq_upper_limit(irq_upper_limit),
    .irq_lower_limit(irq_lower_limit));
